//--- gt_pkg.sv
// Shared constants and types of the gated 16-bit timer
package gt_pkg;
   // Register offsets on the plain register port
   localparam logic [7:0] OFS_CORE_CTRL = 8'h0b;
   localparam logic [7:0] OFS_FLAG = 8'h0c;
   localparam logic [7:0] OFS_COUNT_LO = 8'h0e;
   localparam logic [7:0] OFS_COUNT_HI = 8'h0f;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_CMP_CTRL = 8'h1a;
   localparam logic [7:0] OFS_ENABLE = 8'h8c;
   // Field positions
   localparam int BIT_GIE = 7;
   localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
   localparam int BIT_ROLL = 0;
   localparam int BIT_GSS = 1;
   // Reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic RST_GSS = 1'b1;
   // Count limits and divider
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [1:0] QDIV_LAST = 2'h3;
   localparam logic [2:0] PRE_LIM_1 = 3'h0;
   localparam logic [2:0] PRE_LIM_2 = 3'h1;
   localparam logic [2:0] PRE_LIM_4 = 3'h3;
   localparam logic [2:0] PRE_LIM_8 = 3'h7;
   // Synchronised pin lanes
   localparam int SYN_W = 4;
   localparam int LN_EXT = 0;
   localparam int LN_LPO = 1;
   localparam int LN_GATE = 2;
   localparam int LN_CMP = 3;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic gate_invert;
      logic gate_enable_bit;
      logic [1:0] prescale_select;
      logic lp_osc_enable;
      logic sync_disable;
      logic clock_source_select;
      logic counter_on;
   } gt_ctrl_t;

   // One register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } gt_req_t;
endpackage : gt_pkg

//--- gt_sync.sv
// Two-flop synchroniser for the asynchronous timer pins
`timescale 1ns/10ps
module gt_sync (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [gt_pkg::SYN_W-1:0] async_i,
   output logic [gt_pkg::SYN_W-1:0] sync_o
);
   // Both stages of every lane
   typedef struct packed {
      logic [gt_pkg::SYN_W-1:0] meta;
      logic [gt_pkg::SYN_W-1:0] safe;
   } gt_sync_st_t;

   gt_sync_st_t st; // Registered state
   gt_sync_st_t next_st; // Next state

   // First stage feeds only the second stage
   always_comb
   begin
      next_st.meta = async_i;
      next_st.safe = st.meta;
   end

   // State register
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign sync_o = st.safe;
endmodule : gt_sync

//--- gt_timer.sv
// Gated 16-bit timer/counter with prescaler, register port and interrupt
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
module gt_timer (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic timer_ext_clock_pin_i,
   input wire logic lp_osc_clock_i,
   input wire logic gate_input_pin_i,
   input wire logic comparator_two_output_i,
   input wire logic internal_oscillator_no_clock_output_pin_i,
   input wire logic sleep_i,
   output logic lp_osc_en_o,
   output logic irq_o,
   output logic wake_o
);
   // Whole module state
   typedef struct packed {
      gt_pkg::gt_ctrl_t ctrl;
      logic gss;
      logic flag;
      logic ie;
      logic peripheral_irq_enable;
      logic global_irq_enable;
      logic [15:0] count;
      logic [2:0] pre;
      logic [1:0] qdiv;
      logic armed;
      logic prev_clk;
      logic pend;
      logic [7:0] rdata;
      logic irq;
      logic wake;
      logic lposc;
   } gt_st_t;

   gt_st_t st; // Registered state
   gt_st_t next_st; // Next state
   gt_pkg::gt_req_t req; // Bundled register request
   logic [gt_pkg::SYN_W-1:0] pins; // Synchronised pins
   logic src_clk; // Selected external clock level
   logic rise; // Rising edge of that clock
   logic fall; // Falling edge of that clock
   logic tick; // Instruction cycle enable
   logic gate_raw; // Selected gate source
   logic gate_open; // Gate allows counting
   logic in_evt; // Event entering the prescaler
   logic inc; // Prescaler output, count step
   logic cnt_wr; // Software writes a count byte
   logic flag_clr; // Software clears the flag
   logic [2:0] pre_lim; // Prescaler terminal value

   assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

   // Pins from outside pass two flops first
   gt_sync u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .async_i({comparator_two_output_i, gate_input_pin_i, lp_osc_clock_i, timer_ext_clock_pin_i}),
      .sync_o(pins)
   );

   // Event decode, gate and prescaler
   always_comb
   begin
      // Fosc/4 divider, halted in sleep
      tick = (st.qdiv == gt_pkg::QDIV_LAST) && !sleep_i;
      // LP oscillator replaces the pin when allowed
      if (st.ctrl.lp_osc_enable && internal_oscillator_no_clock_output_pin_i)
      begin
         src_clk = pins[gt_pkg::LN_LPO];
      end
      else
      begin
         src_clk = pins[gt_pkg::LN_EXT];
      end
      rise = src_clk && !st.prev_clk;
      fall = !src_clk && st.prev_clk;
      // Gate source and polarity
      gate_raw = st.gss ? pins[gt_pkg::LN_CMP] : pins[gt_pkg::LN_GATE];
      gate_open = !st.ctrl.gate_enable_bit || !(gate_raw ^ st.ctrl.gate_invert);
      // Source of counting events
      if (!st.ctrl.clock_source_select)
      begin
         in_evt = tick;
      end
      else if (st.ctrl.sync_disable)
      begin
         in_evt = rise && st.armed;
      end
      else
      begin
         in_evt = tick && st.pend;
      end
      in_evt = in_evt && st.ctrl.counter_on && gate_open;
      // Terminal value per prescale setting
      case (st.ctrl.prescale_select)
         2'h0: pre_lim = gt_pkg::PRE_LIM_1;
         2'h1: pre_lim = gt_pkg::PRE_LIM_2;
         2'h2: pre_lim = gt_pkg::PRE_LIM_4;
         2'h3: pre_lim = gt_pkg::PRE_LIM_8;
         default: pre_lim = gt_pkg::PRE_LIM_1;
      endcase
      inc = in_evt && (st.pre == pre_lim);
      cnt_wr = req.wr && (req.addr == gt_pkg::OFS_COUNT_LO || req.addr == gt_pkg::OFS_COUNT_HI);
      // Read of the flag register, or a zero written, clears it
      flag_clr = (req.rd && req.addr == gt_pkg::OFS_FLAG)
         || (req.wr && req.addr == gt_pkg::OFS_FLAG && !req.wdata[gt_pkg::BIT_ROLL]);
   end

   // Next state
   always_comb
   begin
      next_st = st;
      next_st.qdiv = sleep_i ? st.qdiv : st.qdiv + 2'h1;
      next_st.prev_clk = src_clk;
      // Arm on a falling edge, disarm when stopped
      if (!st.ctrl.counter_on || !st.ctrl.clock_source_select)
      begin
         next_st.armed = 1'b0;
      end
      else if (fall)
      begin
         next_st.armed = 1'b1;
      end
      // Edge waits for the next instruction cycle
      if (!st.ctrl.clock_source_select || st.ctrl.sync_disable)
      begin
         next_st.pend = 1'b0;
      end
      else if (rise && st.armed)
      begin
         next_st.pend = 1'b1;
      end
      else if (tick)
      begin
         next_st.pend = 1'b0;
      end
      // Prescaler advance
      if (in_evt)
      begin
         next_st.pre = inc ? 3'h0 : st.pre + 3'h1;
      end
      // Count step and wrap
      if (inc)
      begin
         next_st.count = st.count + 16'h0001;
      end
      // Flag: set beats clear
      if (flag_clr)
      begin
         next_st.flag = 1'b0;
      end
      if (inc && st.count == gt_pkg::COUNT_MAX)
      begin
         next_st.flag = 1'b1;
      end
      // Register writes
      if (req.wr)
      begin
         case (req.addr)
            gt_pkg::OFS_CTRL: next_st.ctrl = req.wdata;
            gt_pkg::OFS_COUNT_LO: next_st.count[7:0] = req.wdata;
            gt_pkg::OFS_COUNT_HI: next_st.count[15:8] = req.wdata;
            gt_pkg::OFS_CMP_CTRL: next_st.gss = req.wdata[gt_pkg::BIT_GSS];
            gt_pkg::OFS_ENABLE: next_st.ie = req.wdata[gt_pkg::BIT_ROLL];
            gt_pkg::OFS_CORE_CTRL:
            begin
               next_st.global_irq_enable = req.wdata[gt_pkg::BIT_GIE];
               next_st.peripheral_irq_enable = req.wdata[gt_pkg::BIT_PERIPHERAL_IRQ_ENABLE];
            end
            default: next_st.ctrl = st.ctrl;
         endcase
      end
      // Count byte write clears the hidden prescaler
      if (cnt_wr)
      begin
         next_st.pre = 3'h0;
      end
      // Read data stand in the following cycle
      next_st.rdata = 8'h00;
      if (req.rd)
      begin
         case (req.addr)
            gt_pkg::OFS_CTRL: next_st.rdata = st.ctrl;
            gt_pkg::OFS_COUNT_LO: next_st.rdata = st.count[7:0];
            gt_pkg::OFS_COUNT_HI: next_st.rdata = st.count[15:8];
            gt_pkg::OFS_FLAG: next_st.rdata = {7'h00, st.flag};
            gt_pkg::OFS_ENABLE: next_st.rdata = {7'h00, st.ie};
            gt_pkg::OFS_CMP_CTRL: next_st.rdata = {6'h00, st.gss, 1'b0};
            gt_pkg::OFS_CORE_CTRL: next_st.rdata = {st.global_irq_enable, st.peripheral_irq_enable, 6'h00};
            default: next_st.rdata = 8'h00;
         endcase
      end
      // Interrupt needs all three enables
      next_st.irq = next_st.flag && next_st.ie && next_st.peripheral_irq_enable && next_st.global_irq_enable;
      // Wake from sleep without the global enable
      next_st.wake = next_st.flag && next_st.ie && next_st.peripheral_irq_enable && sleep_i;
      next_st.lposc = next_st.ctrl.lp_osc_enable && internal_oscillator_no_clock_output_pin_i;
   end

   // State register
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st <= '0;
         st.ctrl <= gt_pkg::RST_CTRL;
         st.count <= gt_pkg::RST_COUNT;
         st.gss <= gt_pkg::RST_GSS;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign rdata_o = st.rdata;
   assign irq_o = st.irq;
   assign wake_o = st.wake;
   assign lp_osc_en_o = st.lposc;

   // Wrap lands on zero with the flag set
   chk_wrap_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (inc && st.count == gt_pkg::COUNT_MAX && !cnt_wr) |=> (st.count == 16'h0000 && st.flag))
      else $error("wrap did not reach zero with flag");

   // Interrupt only with every enable
   chk_irq_enables: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      irq_o |-> (st.flag && st.ie && st.peripheral_irq_enable && st.global_irq_enable))
      else $error("interrupt without all enables");

   // Flag holds until software clears it
   chk_flag_sticky: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (st.flag && !flag_clr) |=> st.flag)
      else $error("rollover flag lost");

   // Count write clears the prescaler
   chk_pre_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      cnt_wr |=> (st.pre == 3'h0))
      else $error("prescaler not cleared by count write");

   // Events short of the terminal value leave the count alone
   chk_pre_limit: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (in_evt && st.pre != pre_lim && !cnt_wr) |=> (st.count == $past(st.count)))
      else $error("count step off the prescale ratio");

   // Stopped counter holds its value
   chk_stop_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (!st.ctrl.counter_on && !cnt_wr) |=> (st.count == $past(st.count)))
      else $error("count moved while stopped");

   // Closed gate holds the count
   chk_gate_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (st.ctrl.gate_enable_bit && (gate_raw ^ st.ctrl.gate_invert) && !cnt_wr)
      |=> (st.count == $past(st.count)))
      else $error("count moved with gate closed");

   // Timer mode steps on instruction cycles
   chk_timer_tick: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (!st.ctrl.clock_source_select && in_evt) |-> (st.qdiv == gt_pkg::QDIV_LAST && !sleep_i))
      else $error("timer event off the instruction cycle");

   // Counter mode needs a prior falling edge
   chk_arm_first: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (st.ctrl.clock_source_select && in_evt) |-> st.armed)
      else $error("edge counted before falling edge");

   // Synchronous counting waits for an instruction cycle
   chk_sync_tick: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (st.ctrl.clock_source_select && !st.ctrl.sync_disable && in_evt) |-> tick)
      else $error("synchronous edge counted off cycle");

   // Sleep does not hold back free-running counting
   chk_sleep_count: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sleep_i && st.ctrl.counter_on && st.ctrl.clock_source_select && st.ctrl.sync_disable
      && gate_open && rise && st.armed) |-> in_evt)
      else $error("asynchronous edge lost in sleep");

   // Internal clock feeds every open instruction cycle
   chk_int_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (!st.ctrl.clock_source_select && st.ctrl.counter_on && gate_open && tick) |-> in_evt)
      else $error("instruction cycle not counted");
endmodule : gt_timer

//--- gt_partner.sv
// Far-side model: external count clock, gate pin, comparator two, LP oscillator
`timescale 1ns/10ps
module gt_partner (
   input wire logic mclk_i,
   output logic ext_o,
   output logic gate_o,
   output logic cmp_o,
   output logic lp_o
);
   // Quiet levels at time zero
   initial
   begin
      ext_o = 1'b0;
      gate_o = 1'b0;
      cmp_o = 1'b0;
      lp_o = 1'b0;
   end

   // LP oscillator runs free, unrelated to mclk
   always #1000 lp_o = ~lp_o;

   // Gate, comparator and idle clock level, set between frames
   task set_lvl(input logic [2:0] v);
      @(posedge mclk_i);
      gate_o <= v[2];
      cmp_o <= v[1];
      ext_o <= v[0];
   endtask : set_lvl

   // Full pulses, each phase four clocks long so the synchroniser sees it
   task pulse(input int n);
      repeat (2 * n)
      begin
         repeat (4) @(posedge mclk_i);
         ext_o <= ~ext_o;
      end
   endtask : pulse
endmodule : gt_partner

//--- gt_timer_tb.sv
// Self-checking bench of the gated 16-bit timer
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
 $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module gt_timer_tb;
   logic mclk_i, rst_n_i, wr_i, rd_i, internal_oscillator, sleep, rd_seen, ok_bit;
   logic [7:0] addr, wdata, rdata, v;
   logic ext, gate, cmp, lp, lp_en, irq, wake;
   int mismatches, samples_checked;
   // Expected read bytes and their allowed shortfall
   logic [7:0] eq[$], tq[$];
   // Reset values, with an unmapped place last
   logic [7:0] ra[8] = '{8'h10, 8'h0e, 8'h0f, 8'h1a, 8'h0c, 8'h8c, 8'h0b, 8'h55};
   logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
   // Control, gate select, pin levels, expected count
   logic [31:0] rows[8] = '{32'h03000005, 32'h07000106, 32'h47000500, 32'hc7000506,
      32'h47020506, 32'h47020300, 32'h17000103, 32'h06000100};

   // Clock at 200 MHz
   initial
   begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   gt_partner PART (.mclk_i(mclk_i), .ext_o(ext), .gate_o(gate), .cmp_o(cmp), .lp_o(lp));

   gt_timer DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata), .timer_ext_clock_pin_i(ext), .lp_osc_clock_i(lp),
      .gate_input_pin_i(gate), .comparator_two_output_i(cmp), .internal_oscillator_no_clock_output_pin_i(internal_oscillator),
      .sleep_i(sleep), .lp_osc_en_o(lp_en), .irq_o(irq), .wake_o(wake));

   // One-cycle register write
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr <= a;
      wdata <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr

   // One-cycle register read, result noted for the monitor
   task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] t);
      eq.push_back(e);
      tq.push_back(t);
      @(posedge mclk_i);
      addr <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
   endtask : rd

   // Read data stand in the cycle after the strobe
   always @(posedge mclk_i)
   begin
      if (rd_seen)
      begin
         ok_bit = 8'(eq.pop_front() - rdata) <= tq.pop_front();
         `CHK(ok_bit, 1'b1)
      end
      rd_seen <= rd_i;
   end

   // Verdict and end of run
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   // Watchdog, well beyond the expected run
   initial
   begin
      #100000;
      mismatches++;
      finish_test;
   end

   // Main sequence
   initial
   begin
      void'($urandom(32'h2ac8227d));
      rst_n_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      internal_oscillator = 1'b0;
      sleep = 1'b0;
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      // Reset values and unmapped read
      foreach (ra[i]) rd(ra[i], rv[i], 8'h00);
      // Count byte holds what was written while stopped
      repeat (4)
      begin
         v = 8'($urandom);
         wr(8'h0e, v);
         rd(8'h0e, v, 8'h00);
      end
      // Timer mode, five steps under each prescale
      for (int p = 0; p < 4; p++)
      begin
         wr(8'h0e, 8'h00);
         wr(8'h0f, 8'h00);
         wr(8'h10, 8'(p << 4) | 8'h01);
         repeat (20 * (1 << p) - 2) @(posedge mclk_i);
         wr(8'h10, 8'h00);
         rd(8'h0e, 8'h05, 8'h00);
      end
      // Count write mid-division restarts the prescaler
      wr(8'h10, 8'h31);
      repeat (10) @(posedge mclk_i);
      wr(8'h10, 8'h00);
      wr(8'h0e, 8'h00);
      wr(8'h10, 8'h31);
      repeat (18) @(posedge mclk_i);
      wr(8'h10, 8'h00);
      rd(8'h0e, 8'h00, 8'h00);
      // Counter mode: edges, sync, gate source and polarity
      foreach (rows[i])
      begin
         wr(8'h10, 8'h00);
         PART.set_lvl(rows[i][10:8]);
         wr(8'h1a, rows[i][23:16]);
         wr(8'h0e, 8'h00);
         wr(8'h0f, 8'h00);
         wr(8'h10, rows[i][31:24]);
         PART.pulse(6);
         repeat (12) @(posedge mclk_i);
         wr(8'h10, 8'h00);
         rd(8'h0e, rows[i][7:0], 8'h00);
      end
      // Rollover with flag cleared and enables set first
      wr(8'h0f, 8'hff);
      wr(8'h0e, 8'hfe);
      wr(8'h0c, 8'h00);
      wr(8'h8c, 8'h01);
      wr(8'h0b, 8'hc0);
      wr(8'h10, 8'h01);
      for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge mclk_i);
      `CHK(irq, 1'b1)
      rd(8'h0c, 8'h01, 8'h00);
      repeat (3) @(posedge mclk_i);
      `CHK(irq, 1'b0)
      // Masked wrap, then unmask, then global off
      wr(8'h8c, 8'h00);
      wr(8'h0f, 8'hff);
      wr(8'h0e, 8'hff);
      repeat (12) @(posedge mclk_i);
      `CHK(irq, 1'b0)
      wr(8'h8c, 8'h01);
      repeat (3) @(posedge mclk_i);
      `CHK(irq, 1'b1)
      wr(8'h0b, 8'h40);
      repeat (3) @(posedge mclk_i);
      `CHK(irq, 1'b0)
      wr(8'h0c, 8'h00);
      rd(8'h0c, 8'h00, 8'h00);
      // Free-running counter wraps in sleep and wakes
      wr(8'h10, 8'h00);
      PART.set_lvl(3'h1);
      wr(8'h0f, 8'hff);
      wr(8'h0e, 8'hff);
      wr(8'h10, 8'h07);
      sleep <= 1'b1;
      PART.pulse(1);
      for (int i = 0; i < 40 && wake !== 1'b1; i++) @(posedge mclk_i);
      `CHK(wake, 1'b1)
      `CHK(irq, 1'b0)
      sleep <= 1'b0;
      wr(8'h10, 8'h00);
      wr(8'h0c, 8'h00);
      // LP oscillator enable only under internal oscillator
      internal_oscillator <= 1'b1;
      wr(8'h10, 8'h08);
      repeat (3) @(posedge mclk_i);
      `CHK(lp_en, 1'b1)
      internal_oscillator <= 1'b0;
      repeat (3) @(posedge mclk_i);
      `CHK(lp_en, 1'b0)
      finish_test;
   end
endmodule : gt_timer_tb
